//--- temp_sensor_i2c_slave_tb.sv
// Testbench driving the host over APB against the sensor end
module temp_sensor_i2c_slave_tb import tsi_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TO = 600;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic addressSelectPin = 1'b0;
  logic [15:0] temperature = 16'h0190;
  logic alertOut;
  logic hsMode;
  logic [31:0] r;
  logic e;
  int err_count = 0;
  int samples_checked = 0;
  always #12.5 clock = ~clock;
  tsi_bus_if bus();
  tsi_host tsi_host_i(.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus));
  tsi_device #(.TIMEOUT_LEN(TO)) tsi_device_i(.clock(clock), .rst(rst), .bus(bus),
    .addressSelectPin(addressSelectPin), .temperature(temperature), .alertOut(alertOut),
    .hsMode(hsMode));
  tsi_link_monitor #(.TO_LEN(TO)) tsi_link_monitor_i(.clock(clock), .rst(rst),
    .hostSclOe(bus.hostSclOe), .devSdaOe(bus.devSdaOe), .sclLine(bus.sclLine),
    .sdaLine(bus.sdaLine), .hsMode(hsMode));
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic qe);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Host drops a command while busy, so every byte waits for busy to clear
  task cmd(input logic [4:0] c, input logic [7:0] d, output logic a, output logic [7:0] q);
    logic [31:0] s;
    logic se;
    apb(1'b1, OFS_CMD, {16'h0000, d, 3'h0, c}, s, se);
    do apb(1'b0, OFS_STATUS, 32'h0, s, se); while (s[STAT_BUSY_BIT] !== 1'b0);
    a = s[STAT_ACK_BIT];
    q = s[15:8];
  endtask
  task wb(input logic [4:0] c, input logic [7:0] d, input logic ea);
    logic a;
    logic [7:0] q;
    cmd(c, d, a, q);
    chk({31'h0, a}, {31'h0, ea});
  endtask
  task rb(input logic [4:0] c, input logic [7:0] ed);
    logic a;
    logic [7:0] q;
    cmd(c, 8'hFF, a, q);
    chk({24'h0, q}, {24'h0, ed});
  endtask
  task readw(input logic [7:0] ad, input logic [15:0] ew);
    wb(5'h05, ad, 1'b1);
    rb(5'h08, ew[15:8]);
    rb(5'h1A, ew[7:0]);
  endtask
  task setreg(input logic [7:0] p, input logic [15:0] v);
    wb(5'h05, 8'h90, 1'b1);
    wb(5'h04, p, 1'b1);
    wb(5'h04, v[15:8], 1'b1);
    wb(5'h06, v[7:0], 1'b1);
  endtask
  initial begin
    // About 96k clocks; a clean run needs roughly three fifths of that
    #2_400_000;
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, OFS_DIV, 32'h0, r, e);
    chk(r, {16'h0000, DIV_RST});
    apb(1'b0, 12'h00C, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    setreg(8'h02, 16'h05A0);
    readw(8'h91, 16'h05A0);
    readw(8'h91, 16'h05A0);
    readw(8'h01, 16'h05A0);
    wb(5'h07, 8'h94, 1'b0);
    wb(5'h05, 8'h00, 1'b1);
    wb(5'h04, 8'h5A, 1'b1);
    wb(5'h06, 8'h33, 1'b0);
    readw(8'h01, 16'h05A0);
    wb(5'h05, 8'h90, 1'b1);
    wb(5'h06, 8'h00, 1'b1);
    readw(8'h91, 16'h0190);
    for (int p = 0; p < 2; p++) begin
      setreg(8'h01, {5'h00, p[0], 10'h200});
      temperature <= 16'h0600;
      repeat (50) @(posedge clock);
      chk({31'h0, alertOut}, {31'h0, p[0]});
      temperature <= 16'h0300;
      repeat (50) @(posedge clock);
      chk({31'h0, alertOut}, {31'h0, ~p[0]});
    end
    wb(5'h05, 8'h08, 1'b0);
    chk({31'h0, hsMode}, 32'h1);
    apb(1'b1, OFS_DIV, 32'h4, r, e);
    wb(5'h05, 8'h90, 1'b1);
    wb(5'h04, 8'h02, 1'b1);
    chk({31'h0, hsMode}, 32'h1);
    readw(8'h91, 16'h05A0);
    repeat (20) @(posedge clock);
    chk({31'h0, hsMode}, 32'h0);
    apb(1'b1, OFS_DIV, 32'h19, r, e);
    wb(5'h05, 8'h91, 1'b1);
    // Slow clock leaves the line low past the trip so the device lets go
    apb(1'b1, OFS_DIV, 32'h190, r, e);
    rb(5'h1A, 8'hFF);
    apb(1'b1, OFS_DIV, 32'h19, r, e);
    readw(8'h91, 16'h05A0);
    addressSelectPin <= 1'b1;
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    wb(5'h07, 8'h92, 1'b1);
    wb(5'h07, 8'h90, 1'b0);
    print_verdict;
  end
endmodule

//--- tsi_bus_if.sv
// Open-drain two-wire bus joining host and device
interface tsi_bus_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic sclLine;
  logic sdaLine;
  // Pull-up wins unless an enabled driver pulls low
  assign sclLine = ~(hostSclOe & ~hostSclOut);
  assign sdaLine = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));
  modport host(output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe, input sclLine, sdaLine);
  modport device(output devSdaOut, devSdaOe, input sclLine, sdaLine);
endinterface

//--- tsi_device.sv
// Temperature sensor serial slave end with alert output
//
// Our own choices: the register addresses and the APB host that drives the bus.
module tsi_device import tsi_pkg::*; #(
  parameter int TIMEOUT_LEN = TIMEOUT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  tsi_bus_if.device bus,
  input wire logic addressSelectPin,
  input wire logic [15:0] temperature,
  output logic alertOut,
  output logic hsMode
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_RX = 5'b00010, S_ACK = 5'b00100, S_TX = 5'b01000, S_TXACK = 5'b10000
  } tsi_dstate_e;

  // Index 0 is SCL, index 1 is SDA
  logic [2:0] sync_reg [2];
  logic [7:0] fltCnt_reg [2];
  logic [1:0] flt_reg;
  logic [1:0] prev_reg;
  logic [2:0] selSync_reg;
  logic sel_reg;
  tsi_dstate_e state_reg;
  logic [3:0] bitCnt_reg;
  logic [1:0] byteCnt_reg;
  logic [7:0] shift_reg;
  logic readMode_reg;
  logic genCall_reg;
  logic lsbPhase_reg;
  logic ackSeen_reg;
  logic [15:0] txWord_reg;
  logic [1:0] ptr_reg;
  logic [7:0] msbHold_reg;
  logic [15:0] config_reg;
  logic [15:0] upper_reg;
  logic [15:0] lower_reg;
  logic sdaOe_reg;
  logic hs_reg;
  logic flag_reg;
  logic alert_reg;
  logic [31:0] tmo_reg;
  logic [7:0] filtLen;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [6:0] ownAddr;
  logic [15:0] ptrWord;

  function automatic logic [15:0] readReg(input logic [1:0] idx);
    logic [15:0] cfg;
    cfg = config_reg;
    cfg[CFG_FLAG_BIT] = flag_reg;
    if (idx == REG_TEMP) begin
      readReg = temperature;
    end else if (idx == REG_CONFIG) begin
      readReg = cfg;
    end else if (idx == REG_UPPER) begin
      readReg = upper_reg;
    end else begin
      readReg = lower_reg;
    end
  endfunction

  assign filtLen = hs_reg ? 8'(FILT_HS_CYC) : 8'(FILT_LS_CYC);
  assign sclRise = flt_reg[0] & ~prev_reg[0];
  assign sclFall = ~flt_reg[0] & prev_reg[0];
  assign startCond = prev_reg[1] & ~flt_reg[1] & flt_reg[0] & prev_reg[0];
  assign stopCond = ~prev_reg[1] & flt_reg[1] & flt_reg[0] & prev_reg[0];
  assign ownAddr = ADDR_BASE | {6'h00, sel_reg};
  // A call result cannot be sliced, so the pointed word gets a net of its own
  assign ptrWord = readReg(ptr_reg);
  // Open drain: only ever pulls data low, clock is never driven
  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOe = sdaOe_reg;
  assign alertOut = alert_reg;
  assign hsMode = hs_reg;

  // Three-flop sync, then a settle counter as the glitch filter
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        sync_reg[i] <= 3'h7;
        fltCnt_reg[i] <= 8'h00;
      end
      flt_reg <= 2'h3;
      prev_reg <= 2'h3;
    end else begin
      sync_reg[0] <= {sync_reg[0][1:0], bus.sclLine};
      sync_reg[1] <= {sync_reg[1][1:0], bus.sdaLine};
      prev_reg <= flt_reg;
      for (int i = 0; i < 2; i++) begin
        if (sync_reg[i][1] == sync_reg[i][2] && sync_reg[i][2] != flt_reg[i]) begin
          if (fltCnt_reg[i] + 8'h01 >= filtLen) begin
            flt_reg[i] <= sync_reg[i][2];
            fltCnt_reg[i] <= 8'h00;
          end else begin
            fltCnt_reg[i] <= fltCnt_reg[i] + 8'h01;
          end
        end else begin
          fltCnt_reg[i] <= 8'h00;
        end
      end
    end
  end

  // Address strap, taken from the pin after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      selSync_reg <= 3'h0;
      sel_reg <= 1'b0;
    end else begin
      selSync_reg <= {selSync_reg[1:0], addressSelectPin};
      if (selSync_reg[1] == selSync_reg[2]) begin
        sel_reg <= selSync_reg[2];
      end
    end
  end

  // Alert comparator; limits compare as two's complement
  always_ff @(posedge clock) begin
    if (rst) begin
      flag_reg <= ~CONFIG_RST[CFG_POL_BIT];
      alert_reg <= ~CONFIG_RST[CFG_POL_BIT];
    end else begin
      if ($signed(temperature) >= $signed(upper_reg)) begin
        flag_reg <= config_reg[CFG_POL_BIT];
      end else if ($signed(temperature) <= $signed(lower_reg)) begin
        flag_reg <= ~config_reg[CFG_POL_BIT];
      end
      // Outside interrupt mode the pin rests at its inactive level
      alert_reg <= config_reg[CFG_IM_BIT] ? flag_reg : ~config_reg[CFG_POL_BIT];
    end
  end

  // Protocol engine, register writes and the clock-low timeout
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= S_IDLE;
      bitCnt_reg <= 4'h0;
      byteCnt_reg <= 2'h0;
      shift_reg <= 8'h00;
      readMode_reg <= 1'b0;
      genCall_reg <= 1'b0;
      lsbPhase_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
      txWord_reg <= 16'h0000;
      ptr_reg <= REG_TEMP;
      msbHold_reg <= 8'h00;
      config_reg <= CONFIG_RST;
      upper_reg <= UPPER_RST;
      lower_reg <= LOWER_RST;
      sdaOe_reg <= 1'b0;
      hs_reg <= 1'b0;
      tmo_reg <= 32'h0000_0000;
    end else begin
      tmo_reg <= (state_reg != S_IDLE && !flt_reg[0]) ? tmo_reg + 32'h0000_0001 : 32'h0000_0000;
      if (stopCond) begin
        state_reg <= S_IDLE;
        sdaOe_reg <= 1'b0;
        hs_reg <= 1'b0;
      end else if (startCond) begin
        state_reg <= S_RX;
        sdaOe_reg <= 1'b0;
        bitCnt_reg <= 4'h0;
        byteCnt_reg <= 2'h0;
      end else if (tmo_reg + 32'h0000_0001 >= 32'(TIMEOUT_LEN)) begin
        state_reg <= S_IDLE;
        sdaOe_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_RX: begin
            if (sclRise && bitCnt_reg != 4'h8) begin
              shift_reg <= {shift_reg[6:0], flt_reg[1]};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall && bitCnt_reg == 4'h8) begin
              state_reg <= S_ACK;
              sdaOe_reg <= 1'b1;
              if (byteCnt_reg == 2'h0) begin
                readMode_reg <= shift_reg[0];
                genCall_reg <= shift_reg[7:1] == GEN_CALL_ADDR;
                byteCnt_reg <= 2'h1;
                if (shift_reg[7:3] == HS_CMD_PREFIX) begin
                  hs_reg <= 1'b1;
                  state_reg <= S_IDLE;
                  sdaOe_reg <= 1'b0;
                end else if (shift_reg[7:1] != ownAddr && shift_reg[7:1] != GEN_CALL_ADDR) begin
                  state_reg <= S_IDLE;
                  sdaOe_reg <= 1'b0;
                end
              end else if (byteCnt_reg == 2'h1) begin
                byteCnt_reg <= 2'h2;
                lsbPhase_reg <= 1'b0;
                if (!genCall_reg) begin
                  ptr_reg <= shift_reg[1:0];
                end
              end else if (genCall_reg) begin
                state_reg <= S_IDLE;
                sdaOe_reg <= 1'b0;
              end else begin
                lsbPhase_reg <= ~lsbPhase_reg;
                if (!lsbPhase_reg) begin
                  msbHold_reg <= shift_reg;
                end else if (ptr_reg == REG_CONFIG) begin
                  config_reg <= {msbHold_reg, shift_reg};
                end else if (ptr_reg == REG_UPPER) begin
                  upper_reg <= {msbHold_reg, shift_reg};
                end else if (ptr_reg == REG_LOWER) begin
                  lower_reg <= {msbHold_reg, shift_reg};
                end
              end
            end
          end
          S_ACK: begin
            if (sclFall) begin
              bitCnt_reg <= 4'h0;
              sdaOe_reg <= 1'b0;
              state_reg <= S_RX;
              if (readMode_reg) begin
                // Word is latched once so MSB and LSB stay consistent
                txWord_reg <= ptrWord;
                shift_reg <= {ptrWord[14:8], 1'b0};
                sdaOe_reg <= ~ptrWord[15];
                lsbPhase_reg <= 1'b1;
                state_reg <= S_TX;
              end
            end
          end
          S_TX: begin
            if (sclFall) begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
              if (bitCnt_reg == 4'h7) begin
                sdaOe_reg <= 1'b0;
                state_reg <= S_TXACK;
              end else begin
                sdaOe_reg <= ~shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
            end
          end
          S_TXACK: begin
            if (sclRise) begin
              ackSeen_reg <= ~flt_reg[1];
            end else if (sclFall) begin
              bitCnt_reg <= 4'h0;
              if (ackSeen_reg) begin
                // MSB then LSB, repeating while the master keeps acking
                shift_reg <= lsbPhase_reg ? {txWord_reg[6:0], 1'b0} : {txWord_reg[14:8], 1'b0};
                sdaOe_reg <= lsbPhase_reg ? ~txWord_reg[7] : ~txWord_reg[15];
                lsbPhase_reg <= ~lsbPhase_reg;
                state_reg <= S_TX;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule

//--- tsi_host.sv
// Bus master end, ordered over APB
module tsi_host import tsi_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tsi_bus_if.host bus
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_START = 4'b0010, H_BIT = 4'b0100, H_STOP = 4'b1000
  } tsi_hstate_e;

  tsi_hstate_e state_reg;
  logic [2:0] sdaSync_reg;
  logic sdaS_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [15:0] cmd_reg;
  logic [15:0] div_reg;
  logic [15:0] qCnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bitIdx_reg;
  logic doByte_reg;
  logic doStop_reg;
  logic [7:0] txShift_reg;
  logic [7:0] rx_reg;
  logic acked_reg;
  logic sclOe_reg;
  logic sdaOe_reg;
  logic access;
  logic wrTake;
  logic tick;

  assign access = psel & penable & ~pready_reg;
  assign wrTake = psel & penable & pready_reg & pwrite;
  assign tick = (qCnt_reg + 16'h0001) >= div_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign bus.hostSclOut = 1'b0;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSclOe = sclOe_reg;
  assign bus.hostSdaOe = sdaOe_reg;

  // Data line from the pin: three flops, counted once the last two agree
  always_ff @(posedge clock) begin
    if (rst) begin
      sdaSync_reg <= 3'h7;
      sdaS_reg <= 1'b1;
    end else begin
      sdaSync_reg <= {sdaSync_reg[1:0], bus.sdaLine};
      if (sdaSync_reg[1] == sdaSync_reg[2]) begin
        sdaS_reg <= sdaSync_reg[2];
      end
    end
  end

  // APB slave; one wait state so read data comes from a flop
  always_ff @(posedge clock) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      div_reg <= DIV_RST;
    end else begin
      pready_reg <= access;
      if (access) begin
        pslverr_reg <= 1'b0;
        prdata_reg <= 32'h0000_0000;
        if (paddr == OFS_CMD) begin
          prdata_reg[15:0] <= cmd_reg;
        end else if (paddr == OFS_STATUS) begin
          prdata_reg[STAT_BUSY_BIT] <= state_reg != H_IDLE;
          prdata_reg[STAT_ACK_BIT] <= acked_reg;
          prdata_reg[STAT_DATA_LSB +: 8] <= rx_reg;
        end else if (paddr == OFS_DIV) begin
          prdata_reg[15:0] <= div_reg;
        end else begin
          pslverr_reg <= 1'b1;
        end
      end
      if (wrTake && paddr == OFS_DIV) begin
        div_reg <= pwdata[15:0];
      end
    end
  end

  // Byte sequencer: optional START, at most one byte, optional STOP per command
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= H_IDLE;
      cmd_reg <= 16'h0000;
      qCnt_reg <= 16'h0000;
      phase_reg <= 2'h0;
      bitIdx_reg <= 4'h0;
      doByte_reg <= 1'b0;
      doStop_reg <= 1'b0;
      txShift_reg <= 8'h00;
      rx_reg <= 8'h00;
      acked_reg <= 1'b0;
      sclOe_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
    end else if (state_reg == H_IDLE) begin
      qCnt_reg <= 16'h0000;
      phase_reg <= 2'h0;
      bitIdx_reg <= 4'h0;
      // Commands written while busy are dropped
      if (wrTake && paddr == OFS_CMD) begin
        cmd_reg <= pwdata[15:0];
        txShift_reg <= pwdata[CMD_DATA_LSB +: 8];
        doByte_reg <= pwdata[CMD_WRITE_BIT] | pwdata[CMD_READ_BIT];
        doStop_reg <= pwdata[CMD_STOP_BIT];
        if (pwdata[CMD_START_BIT]) begin
          state_reg <= H_START;
        end else if (pwdata[CMD_WRITE_BIT] | pwdata[CMD_READ_BIT]) begin
          state_reg <= H_BIT;
        end else if (pwdata[CMD_STOP_BIT]) begin
          state_reg <= H_STOP;
        end
      end
    end else begin
      qCnt_reg <= tick ? 16'h0000 : qCnt_reg + 16'h0001;
      if (tick) begin
        phase_reg <= phase_reg + 2'h1;
        case (state_reg)
          H_START: begin
            // Both lines high, then data falls while clock is high
            case (phase_reg)
              2'h0: sdaOe_reg <= 1'b0;
              2'h1: sclOe_reg <= 1'b0;
              2'h2: sdaOe_reg <= 1'b1;
              default: begin
                sclOe_reg <= 1'b1;
                state_reg <= doByte_reg ? H_BIT : (doStop_reg ? H_STOP : H_IDLE);
              end
            endcase
          end
          H_BIT: begin
            case (phase_reg)
              2'h0: begin
                sclOe_reg <= 1'b1;
                if (bitIdx_reg == 4'h8) begin
                  sdaOe_reg <= cmd_reg[CMD_READ_BIT] & ~cmd_reg[CMD_NACK_BIT];
                end else begin
                  sdaOe_reg <= cmd_reg[CMD_WRITE_BIT] & ~txShift_reg[7];
                end
              end
              2'h1: sclOe_reg <= 1'b0;
              2'h2: begin
                if (bitIdx_reg == 4'h8) begin
                  acked_reg <= ~sdaS_reg;
                end else begin
                  rx_reg <= {rx_reg[6:0], sdaS_reg};
                end
              end
              default: begin
                sclOe_reg <= 1'b1;
                txShift_reg <= {txShift_reg[6:0], 1'b0};
                bitIdx_reg <= bitIdx_reg + 4'h1;
                if (bitIdx_reg == 4'h8) begin
                  state_reg <= doStop_reg ? H_STOP : H_IDLE;
                end
              end
            endcase
          end
          H_STOP: begin
            // Data rises while clock is high
            case (phase_reg)
              2'h0: sdaOe_reg <= 1'b1;
              2'h1: sclOe_reg <= 1'b0;
              2'h2: sdaOe_reg <= 1'b0;
              default: state_reg <= H_IDLE;
            endcase
          end
          default: state_reg <= H_IDLE;
        endcase
      end
    end
  end
endmodule

//--- tsi_link_monitor.sv
// Checker on the two-wire link between host and device
module tsi_link_monitor #(
  parameter int TO_LEN = 2000
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hostSclOe,
  input wire logic devSdaOe,
  input wire logic sclLine,
  input wire logic sdaLine,
  input wire logic hsMode
);
  logic sdaPrev;
  logic startSeen;
  logic stopSeen;
  logic [11:0] sclLowCnt;
  logic [7:0] stopAge;
  logic quiet;
  logic busFree;
  assign startSeen = sclLine & sdaPrev & ~sdaLine;
  assign stopSeen = sclLine & ~sdaPrev & sdaLine;
  always_ff @(posedge clock) begin
    sdaPrev <= rst ? 1'b1 : sdaLine;
  end
  // Saturating so a long idle low never wraps back into the trip value
  always_ff @(posedge clock) begin
    if (rst || sclLine) sclLowCnt <= 12'h000;
    else if (sclLowCnt != 12'hFFF) sclLowCnt <= sclLowCnt + 12'h001;
  end
  always_ff @(posedge clock) begin
    if (rst || stopSeen) stopAge <= 8'h00;
    else if (stopAge != 8'hFF) stopAge <= stopAge + 8'h01;
  end
  always_ff @(posedge clock) begin
    if (rst || startSeen) quiet <= 1'b0;
    else if (sclLowCnt == 12'(TO_LEN + 20)) quiet <= 1'b1;
  end
  always_ff @(posedge clock) begin
    if (rst || stopSeen) busFree <= 1'b1;
    else if (startSeen) busFree <= 1'b0;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_sclFall;
    $fell(sclLine);
  endsequence
  sequence s_nextHigh;
    ##[1:300] $rose(sclLine);
  endsequence
  a_no_scl_drive: assert property (!sclLine |-> hostSclOe)
    else $error("clock line low without host drive");
  a_sda_steady: assert property (sclLine && $past(sclLine) |-> $stable(devSdaOe))
    else $error("device data changed while clock high");
  a_out_hold: assert property (s_sclFall |=> $stable(devSdaOe) [*3])
    else $error("device data changed too soon after clock fall");
  a_hs_to_stop: assert property ($fell(hsMode) |-> stopAge < 8'd24)
    else $error("high speed mode left without stop");
  a_hs_no_ack: assert property ($rose(hsMode) |-> (!devSdaOe throughout s_nextHigh))
    else $error("high speed command acknowledged");
  a_to_release: assert property (sclLowCnt == 12'(TO_LEN + 20) |-> !devSdaOe)
    else $error("data line held after clock low timeout");
  a_to_quiet: assert property (quiet |-> !devSdaOe)
    else $error("device active after timeout before start");
  a_idle_quiet: assert property (busFree |-> !devSdaOe)
    else $error("device drove data with bus idle");
endmodule

//--- tsi_pkg.sv
// Shared constants for the temperature sensor two-wire link
package tsi_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // Slave address: base plus the address select pin
  localparam logic [6:0] ADDR_BASE = 7'h48;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [4:0] HS_CMD_PREFIX = 5'h01;
  // Bus rate limits, for reference by the host divider
  localparam int FAST_MAX_KHZ = 400;
  localparam int HS_MAX_KHZ = 3400;
  localparam int MIN_KHZ = 1;
  // SCL-low timeout
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
  // Input filter time constants
  localparam int FILT_LS_NS = 100;
  localparam int FILT_HS_NS = 25;
  localparam int FILT_LS_CYC = (CLK_MHZ * FILT_LS_NS / 1000 < 1) ? 1 : CLK_MHZ * FILT_LS_NS / 1000;
  localparam int FILT_HS_CYC = (CLK_MHZ * FILT_HS_NS / 1000 < 1) ? 1 : CLK_MHZ * FILT_HS_NS / 1000;
  // Device register indices and reset values
  localparam logic [1:0] REG_TEMP = 2'h0;
  localparam logic [1:0] REG_CONFIG = 2'h1;
  localparam logic [1:0] REG_UPPER = 2'h2;
  localparam logic [1:0] REG_LOWER = 2'h3;
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [15:0] UPPER_RST = 16'h0500;
  localparam logic [15:0] LOWER_RST = 16'h0400;
  localparam int CFG_FLAG_BIT = 5;
  localparam int CFG_IM_BIT = 9;
  localparam int CFG_POL_BIT = 10;
  // Host APB register map
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_DIV = 12'h008;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_WRITE_BIT = 2;
  localparam int CMD_READ_BIT = 3;
  localparam int CMD_NACK_BIT = 4;
  localparam int CMD_DATA_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACK_BIT = 1;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [15:0] DIV_RST = 16'h0019;
endpackage
